// ==== cmp_digital.sv ====
// Digital side of the two-comparator block: control register, result
// polarity, pin routing, change flag and interrupt gating.
// Assumes raw comparator outputs arrive asynchronously from the analog
// macro and registers are reached over a plain one-cycle port.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cmp_digital
    import cmp_pkg::*;
#(
    parameter int PORT_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [cmp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [cmp_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [cmp_pkg::DATA_W-1:0] reg_rdata,
    input wire logic raw_cmp1,
    input wire logic raw_cmp2,
    input wire logic [PORT_W-1:0] pin_in,
    input wire logic sleeping,
    output logic cmp1_on,
    output logic cmp2_on,
    output logic vref_to_pos,
    output logic neg_from_ref_pins,
    output logic [PORT_W-1:0] pin_out,
    output logic [PORT_W-1:0] pin_oe,
    output logic [3:0] pin_analog_config,
    output logic irq_req,
    output logic wake_req
);
    import cmp_pkg::*;

    logic [2:0] compare_mode_sel_q;
    logic input_switch_bit_q;
    logic first_polarity_bit_q;
    logic second_polarity_bit_q;
    logic [7:0] flags2_q;
    logic [7:0] enables2_q;
    logic [7:0] prios2_q;
    logic [7:0] irq_control_q;
    logic [PORT_W-1:0] port_direction_q;
    logic [PORT_W-1:0] port_latch_q;
    logic [3:0] ana_cfg_q;
    logic [1:0] c1_sync_q;
    logic [1:0] c2_sync_q;
    logic [PORT_W-1:0] pin_s1_q;
    logic [PORT_W-1:0] pin_s2_q;
    logic first_result_bit;
    logic second_result_bit;
    logic ctrl_access;
    logic mis1;
    logic mis2;
    logic change_set;
    logic pins_drive_results;
    logic [PORT_W-1:0] analog_pins;
    logic [PORT_W-1:0] port_view;
    logic [7:0] rdata_d;

    // Two-flop synchronisers for analog results and pins
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            c1_sync_q <= 2'h0;
            c2_sync_q <= 2'h0;
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end
        else
        begin
            c1_sync_q <= {c1_sync_q[0], raw_cmp1};
            c2_sync_q <= {c2_sync_q[0], raw_cmp2};
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Result polarity; analog gives one when positive above negative
    assign first_result_bit = c1_sync_q[1] ^ first_polarity_bit_q;
    assign second_result_bit = c2_sync_q[1] ^ second_polarity_bit_q;

    assign ctrl_access = (reg_rd | reg_wr) & (reg_addr == OFS_CMP_CTRL);

    // One snapshot per comparator; access ends the mismatch
    result_snap u_snap1 (
        .sys_clk(sys_clk),
        .rst(rst),
        .live(first_result_bit),
        .capture(ctrl_access),
        .mismatch(mis1)
    );
    result_snap u_snap2 (
        .sys_clk(sys_clk),
        .rst(rst),
        .live(second_result_bit),
        .capture(ctrl_access),
        .mismatch(mis2)
    );
    // A change coinciding with an access is absorbed into the snapshot
    assign change_set = mis1 | mis2;

    // Comparator control; untouched by sleep, reset selects off mode
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            compare_mode_sel_q <= MODE_RESET;
            input_switch_bit_q <= 1'b0;
            first_polarity_bit_q <= 1'b0;
            second_polarity_bit_q <= 1'b0;
        end
        else if (reg_wr && reg_addr == OFS_CMP_CTRL)
        begin
            // Result bits ignore writes
            compare_mode_sel_q <= reg_wdata[MODE_HI:MODE_LO];
            input_switch_bit_q <= reg_wdata[BIT_SWITCH];
            first_polarity_bit_q <= reg_wdata[BIT_POL1];
            second_polarity_bit_q <= reg_wdata[BIT_POL2];
        end
    end

    // Peripheral flags; hardware set wins over a software clear
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            flags2_q <= RST_ZERO;
        else
        begin
            if (reg_wr && reg_addr == OFS_FLAGS2)
                flags2_q <= reg_wdata & FLAGS2_MASK;
            if (change_set)
                flags2_q[BIT_CHG] <= 1'b1;
        end
    end

    // Enable, priority and irq control registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            enables2_q <= RST_ZERO;
            prios2_q <= RST_ZERO;
            irq_control_q <= RST_ZERO;
        end
        else if (reg_wr)
        begin
            if (reg_addr == OFS_ENABLES2)
                enables2_q <= reg_wdata & PERIPHERAL_ENABLES_TWO_MASK;
            if (reg_addr == OFS_PRIOS2)
                prios2_q <= reg_wdata & PERIPHERAL_ENABLES_TWO_MASK;
            if (reg_addr == OFS_IRQ_CTRL)
                irq_control_q <= reg_wdata;
        end
    end

    // Port direction, latch and analog configuration
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            port_direction_q <= PORT_W'(RST_PORT_DIR);
            port_latch_q <= '0;
            ana_cfg_q <= RST_ANA_CFG;
        end
        else if (reg_wr)
        begin
            if (reg_addr == OFS_PORT_DIR)
                port_direction_q <= PORT_W'(reg_wdata);
            if (reg_addr == OFS_PORT_LATCH)
                port_latch_q <= PORT_W'(reg_wdata);
            if (reg_addr == OFS_PORT_READ)
                ana_cfg_q <= reg_wdata[3:0];
        end
    end

    // Pins 0..3 analog while config field is below 4'hb (simplified)
    always_comb
    begin
        analog_pins = '0;
        analog_pins[3:0] = (ana_cfg_q < ANA_CFG_DIGITAL) ? 4'hf : 4'h0;
        port_view = pin_s2_q & ~analog_pins;
    end

    assign pins_drive_results = (compare_mode_sel_q == MODE_PIN_OUT_A) ||
        (compare_mode_sel_q == MODE_PIN_OUT_B);

    // Read mux, answered the cycle after the strobe
    always_comb
    begin
        rdata_d = RST_ZERO;
        unique case (reg_addr)
            OFS_CMP_CTRL: rdata_d = {second_result_bit, first_result_bit,
                second_polarity_bit_q, first_polarity_bit_q,
                input_switch_bit_q, compare_mode_sel_q};
            OFS_FLAGS2: rdata_d = flags2_q;
            OFS_ENABLES2: rdata_d = enables2_q;
            OFS_PRIOS2: rdata_d = prios2_q;
            OFS_IRQ_CTRL: rdata_d = irq_control_q;
            OFS_PORT_DIR: rdata_d = 8'(port_direction_q);
            OFS_PORT_LATCH: rdata_d = 8'(port_latch_q);
            OFS_PORT_READ: rdata_d = 8'(port_view);
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            reg_rdata <= RST_ZERO;
        else if (reg_rd)
            reg_rdata <= rdata_d;
        else
            reg_rdata <= RST_ZERO;
    end

    // Analog control outputs registered; comparators stay on in sleep
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cmp1_on <= 1'b0;
            cmp2_on <= 1'b0;
            vref_to_pos <= 1'b0;
            neg_from_ref_pins <= 1'b0;
        end
        else
        begin
            cmp1_on <= compare_mode_sel_q != MODE_OFF;
            cmp2_on <= compare_mode_sel_q != MODE_OFF;
            vref_to_pos <= compare_mode_sel_q == MODE_MUX4_VREF;
            neg_from_ref_pins <= (compare_mode_sel_q == MODE_MUX4_VREF) &
                input_switch_bit_q;
        end
    end

    // Pin drivers; registered result path trades a cycle for clean outputs
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pin_out <= '0;
            pin_oe <= '0;
        end
        else
        begin
            pin_out <= port_latch_q;
            pin_oe <= ~port_direction_q;
            if (pins_drive_results)
            begin
                pin_out[PIN_RES1] <= raw_cmp1 ^ first_polarity_bit_q;
                pin_out[PIN_RES2] <= raw_cmp2 ^ second_polarity_bit_q;
            end
        end
    end

    // Interrupt needs flag, enable and both global enables
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            irq_req <= 1'b0;
            wake_req <= 1'b0;
            pin_analog_config <= RST_ANA_CFG;
        end
        else
        begin
            irq_req <= flags2_q[BIT_CHG] & enables2_q[BIT_CHG] &
                irq_control_q[BIT_PERIPHERAL_IRQ_ENABLE] & irq_control_q[BIT_GIE];
            wake_req <= sleeping & flags2_q[BIT_CHG] &
                enables2_q[BIT_CHG];
            pin_analog_config <= ana_cfg_q;
        end
    end

    // Checks on flag, interrupt, mode decode and read path
    a_irq_gate: assert property (@(posedge sys_clk)
        disable iff (rst)
        irq_req |-> $past(flags2_q[BIT_CHG] & enables2_q[BIT_CHG] &
        irq_control_q[BIT_GIE] & irq_control_q[BIT_PERIPHERAL_IRQ_ENABLE]))
        else $error("irq without all enables");
    a_irq_raised: assert property (@(posedge sys_clk)
        disable iff (rst)
        flags2_q[BIT_CHG] && enables2_q[BIT_CHG] &&
        irq_control_q[BIT_GIE] && irq_control_q[BIT_PERIPHERAL_IRQ_ENABLE] |=> irq_req)
        else $error("enabled flag gave no irq");
    a_flag_set: assert property (@(posedge sys_clk)
        disable iff (rst)
        change_set |=> flags2_q[BIT_CHG])
        else $error("change did not set flag");
    a_flag_soft: assert property (@(posedge sys_clk)
        disable iff (rst)
        reg_wr && reg_addr == OFS_FLAGS2 && reg_wdata[BIT_CHG]
        |=> flags2_q[BIT_CHG])
        else $error("written one did not set flag");
    a_reset_mode: assert property (@(posedge sys_clk)
        rst |=> compare_mode_sel_q == MODE_RESET)
        else $error("reset mode not off");
    a_access_clears: assert property (@(posedge sys_clk)
        disable iff (rst)
        ctrl_access ##1 !ctrl_access && $stable(first_result_bit) &&
        $stable(second_result_bit) |-> !change_set)
        else $error("mismatch persists after access");
    a_vref_mode: assert property (@(posedge sys_clk)
        disable iff (rst)
        vref_to_pos |-> $past(compare_mode_sel_q) == MODE_MUX4_VREF)
        else $error("vref outside mux mode");
    a_neg_switch: assert property (@(posedge sys_clk)
        disable iff (rst)
        neg_from_ref_pins |-> $past(input_switch_bit_q) &&
        $past(compare_mode_sel_q) == MODE_MUX4_VREF)
        else $error("negative inputs switched outside mode");
    a_polarity: assert property (@(posedge sys_clk)
        disable iff (rst)
        $past(reg_rd && reg_addr == OFS_CMP_CTRL) |->
        reg_rdata[BIT_RES1] == ($past(c1_sync_q[1]) ^
        $past(first_polarity_bit_q)) && reg_rdata[BIT_RES2] ==
        ($past(c2_sync_q[1]) ^ $past(second_polarity_bit_q)))
        else $error("polarity wrong");
    a_analog_zero: assert property (@(posedge sys_clk)
        disable iff (rst)
        $past(reg_rd && reg_addr == OFS_PORT_READ &&
        ana_cfg_q == RST_ANA_CFG) |-> reg_rdata[3:0] == 4'h0)
        else $error("analog pin read nonzero");
    a_pin_oe: assert property (@(posedge sys_clk)
        disable iff (rst)
        pin_oe[PIN_RES1] == !$past(port_direction_q[PIN_RES1]))
        else $error("pin enable not from direction");
    a_result_pin: assert property (@(posedge sys_clk)
        disable iff (rst)
        pins_drive_results |=> pin_out[PIN_RES1] ==
        ($past(raw_cmp1) ^ $past(first_polarity_bit_q)))
        else $error("result pin wrong");
    a_wake_gate: assert property (@(posedge sys_clk)
        disable iff (rst)
        wake_req |-> $past(sleeping && flags2_q[BIT_CHG] &&
        enables2_q[BIT_CHG]))
        else $error("wake without enabled flag in sleep");
endmodule
`default_nettype wire

// ==== cmp_pkg.sv ====
// Package for the dual comparator digital block: offsets, fields, resets.
// Assumes an 8-bit register port with one-cycle read latency.
package cmp_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    // Register indices on the plain register port
    localparam logic [2:0] OFS_CMP_CTRL = 3'h0;
    localparam logic [2:0] OFS_FLAGS2 = 3'h1;
    localparam logic [2:0] OFS_ENABLES2 = 3'h2;
    localparam logic [2:0] OFS_PRIOS2 = 3'h3;
    localparam logic [2:0] OFS_IRQ_CTRL = 3'h4;
    localparam logic [2:0] OFS_PORT_DIR = 3'h5;
    localparam logic [2:0] OFS_PORT_LATCH = 3'h6;
    localparam logic [2:0] OFS_PORT_READ = 3'h7;
    // Comparator control fields
    localparam int BIT_RES2 = 7;
    localparam int BIT_RES1 = 6;
    localparam int BIT_POL2 = 5;
    localparam int BIT_POL1 = 4;
    localparam int BIT_SWITCH = 3;
    localparam int MODE_HI = 2;
    localparam int MODE_LO = 0;
    // Change flag/enable position, irq control positions
    localparam int BIT_CHG = 6;
    localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
    localparam int BIT_GIE = 7;
    // Port pins carrying comparator results
    localparam int PIN_RES1 = 4;
    localparam int PIN_RES2 = 5;
    // Modes
    localparam logic [2:0] MODE_MUX4_VREF = 3'h6;
    localparam logic [2:0] MODE_OFF = 3'h7;
    localparam logic [2:0] MODE_RESET = 3'h7;
    // Modes that drive pins with results (choice: 011 and 101 style)
    localparam logic [2:0] MODE_PIN_OUT_A = 3'h3;
    localparam logic [2:0] MODE_PIN_OUT_B = 3'h5;
    // Reset values
    localparam logic [7:0] RST_PORT_DIR = 8'hff;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [3:0] RST_ANA_CFG = 4'h0;
    // Config codes from this value up leave the low pins digital
    localparam logic [3:0] ANA_CFG_DIGITAL = 4'hb;
    localparam logic [7:0] FLAGS2_MASK = 8'hdf;
    localparam logic [7:0] PERIPHERAL_ENABLES_TWO_MASK = 8'hdf;
endpackage

// ==== result_snap.sv ====
// Snapshot register for one comparator result and its mismatch term.
// Assumes a synchronised live result from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module result_snap (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic live,
    input wire logic capture,
    output logic mismatch
);
    logic snap_q;

    // Snapshot taken on each control register access
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            snap_q <= 1'b0;
        else if (capture)
            snap_q <= live;
    end

    // Differs from snapshot: change still pending
    assign mismatch = (live != snap_q) & ~capture;
endmodule
`default_nettype wire

// ==== analog_front.sv ====
// Behavioural analog side: two comparators and their input levels.
// Assumes the bench sets pin levels and the reference in plain units.
`timescale 1ns/100ps
`default_nettype none
module analog_front (
    input wire logic [3:0][7:0] ain,
    input wire logic [7:0] vref,
    input wire logic cmp1_on,
    input wire logic cmp2_on,
    input wire logic vref_to_pos,
    input wire logic neg_from_ref_pins,
    output wire logic raw_cmp1,
    output wire logic raw_cmp2
);
    logic [7:0] pos1;
    logic [7:0] pos2;
    logic [7:0] neg1;
    logic [7:0] neg2;
    // Reference reaches both positive inputs only when selected
    assign pos1 = vref_to_pos ? vref : ain[3];
    assign pos2 = vref_to_pos ? vref : ain[2];
    // Switch picks the reference-capable pins as negative inputs
    assign neg1 = neg_from_ref_pins ? ain[3] : ain[0];
    assign neg2 = neg_from_ref_pins ? ain[2] : ain[1];
    // Response delay, not clock aligned; a powered-down unit rests low
    assign #7 raw_cmp1 = cmp1_on && (pos1 > neg1);
    assign #7 raw_cmp2 = cmp2_on && (pos2 > neg2);
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the dual comparator digital block.
// Assumes the analog model on the far side and one 40 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import cmp_pkg::*;
    logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rd_q = 0;
    logic sleeping = 0;
    logic [2:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0, pin_in = '0, vref = '0;
    logic [7:0] reg_rdata, pin_out, pin_oe;
    logic [3:0][7:0] ain = '0;
    logic [3:0] pin_analog_config;
    logic raw_cmp1, raw_cmp2, cmp1_on, cmp2_on;
    logic vref_to_pos, neg_from_ref_pins, irq_req, wake_req;
    int fail_count = 0, cmp_count = 0;
    logic [7:0] exp_q [$];

    // Clock at 25 ns
    always #12.5 sys_clk = ~sys_clk;

    cmp_digital #(.PORT_W(8)) cmp_digital_inst (.sys_clk, .rst,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .raw_cmp1,
        .raw_cmp2, .pin_in, .sleeping, .cmp1_on, .cmp2_on, .vref_to_pos,
        .neg_from_ref_pins, .pin_out, .pin_oe, .pin_analog_config,
        .irq_req, .wake_req);

    analog_front analog_front_inst (.ain, .vref, .cmp1_on, .cmp2_on,
        .vref_to_pos, .neg_from_ref_pins, .raw_cmp1, .raw_cmp2);

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Expected read data is queued for the monitor
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge sys_clk)
    begin
        if (rd_q)
            chk(reg_rdata, exp_q.pop_front());
        rd_q <= reg_rd;
    end

    // Cut a hang short well past the expected run length
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        fail_count++;
        tally_and_finish;
    end

    initial
    begin
        void'($urandom(82011));
        pin_in <= 8'($urandom);
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        // Reset state
        rd(OFS_CMP_CTRL, 8'h07);
        rd(OFS_FLAGS2, 8'h00);
        rd(OFS_PORT_DIR, 8'hff);
        rd(OFS_PORT_READ, {pin_in[7:4], 4'h0});
        w(1);
        chk(irq_req, 1'b0);
        // Every mode, switch bit set, result bits written high
        for (int m = 0; m < 8; m++)
        begin
            wr(OFS_CMP_CTRL, 8'hc8 | 8'(m));
            w(2);
            chk(vref_to_pos, m == 6);
            chk(neg_from_ref_pins, m == 6);
            chk(cmp1_on, m != 7);
            chk(cmp2_on, m != 7);
            rd(OFS_CMP_CTRL, 8'h08 | 8'(m));
        end
        // Both results rise; flag cannot be cleared before a control register read
        wr(OFS_CMP_CTRL, 8'h06);
        vref <= 8'd100;
        w(8);
        chk(irq_req, 1'b0);
        wr(OFS_FLAGS2, 8'h00);
        rd(OFS_FLAGS2, 8'h40);
        rd(OFS_CMP_CTRL, 8'hc6);
        w(2);
        wr(OFS_FLAGS2, 8'h00);
        rd(OFS_FLAGS2, 8'h00);
        // Polarity inverts both results
        wr(OFS_CMP_CTRL, 8'h36);
        w(4);
        rd(OFS_CMP_CTRL, 8'h36);
        w(2);
        wr(OFS_FLAGS2, 8'hff);
        rd(OFS_FLAGS2, 8'hdf);
        // All enable combinations with the flag set by software
        for (int i = 0; i < 8; i++)
        begin
            wr(OFS_ENABLES2, {1'b0, i[0], 6'h00});
            wr(OFS_IRQ_CTRL, {i[2], i[1], 6'h00});
            w(2);
            chk(irq_req, i == 7);
        end
        chk(wake_req, 1'b0);
        sleeping <= 1'b1;
        w(3);
        chk(wake_req, 1'b1);
        sleeping <= 1'b0;
        rd(OFS_CMP_CTRL, 8'h36);
        wr(OFS_IRQ_CTRL, 8'h00);
        // Software turns both off before sleeping; results read inverted
        wr(OFS_CMP_CTRL, 8'h37);
        sleeping <= 1'b1;
        w(3);
        chk(cmp1_on, 1'b0);
        sleeping <= 1'b0;
        rd(OFS_CMP_CTRL, 8'hf7);
        // Results routed to the two pins, direction still gates them
        wr(OFS_PORT_DIR, 8'hef);
        wr(OFS_CMP_CTRL, 8'h03);
        ain[3] <= 8'd50;
        w(4);
        chk(pin_out[4], 1'b1);
        chk(pin_oe[4], 1'b1);
        chk(pin_oe[5], 1'b0);
        wr(OFS_CMP_CTRL, 8'h13);
        w(3);
        chk(pin_out[4], 1'b0);
        wr(OFS_PORT_DIR, 8'hcf);
        wr(OFS_CMP_CTRL, 8'h25);
        w(3);
        chk(pin_out[5], 1'b1);
        chk(pin_oe[5], 1'b1);
        // All pins digital, so the port reads every level
        wr(OFS_PORT_READ, 8'h0f);
        w(2);
        chk(pin_analog_config, 4'hf);
        rd(OFS_PORT_READ, pin_in);
        w(2);
        tally_and_finish;
    end
endmodule
`default_nettype wire
